// [inc/mbd_pkg.sv]
// Constants and register map of the media buffer register datapath
package mbd_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CMD = 5'h00;
  localparam logic [4:0] OFS_MODE = 5'h04;
  localparam logic [4:0] OFS_SWITCH = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0c;
  localparam logic [4:0] OFS_DATA = 5'h10;
  localparam logic [4:0] OFS_MEMBUF = 5'h14;

  // ----------------------------------------------------------------
  // Command bit positions
  // ----------------------------------------------------------------
  localparam int CMD_START = 0;
  localparam int CMD_CLEAR = 1;
  localparam int CMD_HALT = 2;
  localparam int CMD_EMERG = 3;
  localparam int CMD_READ_IN = 4;
  localparam int CMD_TO_MEM = 5;
  localparam int CMD_IN_SHIFT = 6;
  localparam int CMD_FETCH = 7;
  localparam int CMD_TO_OUT = 8;
  localparam int CMD_OUT_SHIFT = 9;
  localparam int CMD_W = 10;

  // ----------------------------------------------------------------
  // Mode fields and media encodings
  // ----------------------------------------------------------------
  localparam int MODE_IN_LSB = 0;
  localparam int MODE_OUT_LSB = 2;
  localparam int MODE_HOLL = 4;
  localparam int MODE_IGNORE = 5;
  localparam logic [5:0] MODE_RESET = 6'h00;
  localparam logic [1:0] IN_MAG = 2'h0;
  localparam logic [1:0] IN_PAPER = 2'h1;
  localparam logic [1:0] IN_CARD = 2'h2;
  localparam logic [1:0] OUT_PAPER = 2'h1;

  // ----------------------------------------------------------------
  // Mark character codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_DELETE = 8'hff;
  localparam logic [7:0] CODE_BLANK = 8'h00;
  localparam logic [7:0] CODE_STOP = 8'h4f;
  localparam logic [7:0] CODE_EOF = 8'h4e;
  localparam logic [7:0] CODE_SCB = 8'h4d;
  localparam logic [7:0] CODE_SB = 8'h4c;
  localparam logic [7:0] CODE_ECB = 8'h4b;
  localparam logic [7:0] CODE_EOB = 8'h4a;

  // ----------------------------------------------------------------
  // Fill levels of the memory holding register, in bits
  // ----------------------------------------------------------------
  localparam logic [4:0] FILL_EMPTY = 5'h00;
  localparam logic [4:0] FILL_HALF = 5'h08;
  localparam logic [4:0] FILL_FULL = 5'h10;

endpackage

// [rtl/mbd_datapath.sv]
// Input, memory and output holding registers with panel control
`timescale 1ns/1ps
module mbd_datapath
  import mbd_pkg::*;
#(
  parameter int ADDR_W = 9,
  parameter int MEM_WORDS = 336
)
(
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic IN_STROBE,
  input wire logic [7:0] IN_DATA,
  output logic [7:0] FWD_CONV_IN,
  input wire logic [15:0] FWD_CONV_DATA,
  input wire logic FWD_CONV_ERR,
  output logic [ADDR_W-1:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  output logic MEM_WE,
  output logic MEM_RD,
  input wire logic [15:0] MEM_RDATA,
  output logic [15:0] REV_CONV_IN,
  input wire logic [7:0] REV_CONV_DATA,
  output logic [7:0] OUT_DATA,
  output logic OUT_STROBE,
  input wire logic OUT_DEV_ERR,
  output logic RUNNING
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic ack_r;
  logic [31:0] rdata_r;
  logic [5:0] mode_r;
  logic [22:0] switch_r;
  logic [7:0] in_r;
  logic [15:0] mem_r;
  logic [15:0] mem_nxt;
  logic [4:0] fill_r;
  logic [4:0] fill_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] out_r;
  logic out_stb_r;
  logic running_r;
  logic running_nxt;
  logic halt_pend_r;
  logic emerg_pend_r;
  logic in_err_r;
  logic out_err_r;
  logic par_err_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire access = AVS_READ | AVS_WRITE;
  wire wr_take = AVS_WRITE & ack_r;
  wire [31:0] be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                         {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  wire [31:0] wdata = AVS_WRITEDATA & be_mask;
  wire sel_cmd = AVS_ADDRESS[4:2] == OFS_CMD[4:2];
  wire sel_mode = AVS_ADDRESS[4:2] == OFS_MODE[4:2];
  wire sel_switch = AVS_ADDRESS[4:2] == OFS_SWITCH[4:2];
  wire [CMD_W-1:0] cmd = (wr_take & sel_cmd) ? wdata[CMD_W-1:0] : '0;
  wire cmd_clear = cmd[CMD_CLEAR];
  wire clr = !RESET_N | cmd_clear;

  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  wire [1:0] in_media = mode_r[MODE_IN_LSB +: 2];
  wire [1:0] out_media = mode_r[MODE_OUT_LSB +: 2];
  wire holl = mode_r[MODE_HOLL];
  wire ignore_err = mode_r[MODE_IGNORE];
  wire paper_in = in_media == IN_PAPER;
  wire card_in = in_media == IN_CARD;
  wire paper_out = out_media == OUT_PAPER;
  wire fwd_sel = holl & ~card_in;
  wire rev_sel = holl & card_in;
  wire [7:0] input_switch_reg = switch_r[7:0];
  wire [6:0] mark_sw = switch_r[14:8];
  wire [6:0] key_sw = switch_r[22:16];

  // ----------------------------------------------------------------
  // Input holding register decodes
  // ----------------------------------------------------------------
  wire in_even = ~^in_r;
  wire in_par_ok = paper_in ? in_even : ~in_even;
  wire in_control = paper_in ? (in_r[5] == in_r[6]) : ~in_r[6];
  wire det_delete = in_r == CODE_DELETE;
  wire det_blank = in_r == CODE_BLANK;
  wire det_stop = in_r == CODE_STOP;
  wire det_eof = in_r == CODE_EOF;
  wire det_scb = in_r == CODE_SCB;
  wire det_sb = in_r == CODE_SB;
  wire det_mark = in_r[6:0] == mark_sw;
  wire det_key = (in_media == IN_MAG) & (in_r[6:0] == key_sw);
  wire [8:0] in_flags = {det_key, det_mark, in_even, det_sb, det_scb,
                         det_eof, det_stop, det_blank, det_delete};

  // Paper tape to stored format: data bit forced, odd parity rebuilt
  wire [6:0] fmt7 = {in_r[5] ^ in_r[6], in_r[5:0]};
  wire [7:0] stored_byte = paper_in ? {~^fmt7, fmt7} : in_r;

  // ----------------------------------------------------------------
  // Memory and output holding register decodes
  // ----------------------------------------------------------------
  wire [7:0] hi_byte = mem_r[15:8];
  wire mem_eob = (hi_byte == CODE_EOB) | (mem_r[7:0] == CODE_EOB);
  wire [6:0] pt7 = {hi_byte[6] ? ~hi_byte[5] : hi_byte[5], hi_byte[5:0]};
  wire [7:0] direct_out = paper_out ? {^pt7, pt7} : hi_byte;
  wire out_end = (out_r == CODE_EOF) | (out_r == CODE_ECB) |
                 (out_r == CODE_EOB);
  wire out_start = (out_r == CODE_SB) | (out_r == CODE_SCB);
  wire rd_par_bad = ~^MEM_RDATA[15:8] | ~^MEM_RDATA[7:0];

  // ----------------------------------------------------------------
  // Operation strobes; each shift yields to its parallel move
  // ----------------------------------------------------------------
  wire run = running_r;
  wire busy = wr_pend_r | rd_pend_r;
  wire to_mem_go = run & cmd[CMD_TO_MEM] & ~busy;
  wire fwd_take = to_mem_go & fwd_sel & (fill_r == FILL_EMPTY) &
                  ~FWD_CONV_ERR;
  wire dir_take = to_mem_go & ~fwd_sel & (fill_r <= FILL_HALF) &
                  in_par_ok;
  wire in_err_ev = to_mem_go & (fwd_sel ? FWD_CONV_ERR : ~in_par_ok);
  wire in_shift_go = run & cmd[CMD_IN_SHIFT] & ~busy & ~to_mem_go &
                     (fill_r < FILL_FULL);
  wire fetch_go = run & cmd[CMD_FETCH] & ~busy & (fill_r == FILL_EMPTY);
  wire to_out_go = run & cmd[CMD_TO_OUT] & ~busy &
                   (rev_sel ? (fill_r == FILL_FULL) : (fill_r >= FILL_HALF));
  wire out_shift_go = run & cmd[CMD_OUT_SHIFT] & ~busy & ~to_out_go &
                      (fill_r != FILL_EMPTY);
  wire out_err_ev = run & OUT_DEV_ERR;
  wire out_cycle_end = (to_out_go & (rev_sel | (fill_r == FILL_HALF))) |
                       (out_shift_go & (fill_r == 5'h01));
  wire op_cycle = (run & IN_STROBE) | to_mem_go | in_shift_go | fetch_go |
                  to_out_go | out_shift_go | busy;
  wire halt_now = (emerg_pend_r & op_cycle) |
                  (halt_pend_r & out_cycle_end) |
                  ((in_err_ev | out_err_ev) & ~ignore_err);
  wire [ADDR_W-1:0] addr_inc = (addr_r == ADDR_W'(MEM_WORDS - 1)) ?
                               '0 : addr_r + 1'b1;

  // Next contents and fill level of the memory holding register
  always_comb
  begin
    mem_nxt = mem_r;
    fill_nxt = fill_r;
    if (wr_pend_r)
    begin
      fill_nxt = FILL_EMPTY;
    end
    else if (rd_pend_r)
    begin
      mem_nxt = MEM_RDATA;
      fill_nxt = FILL_FULL;
    end
    else if (fwd_take)
    begin
      mem_nxt = FWD_CONV_DATA;
      fill_nxt = FILL_FULL;
    end
    else if (dir_take)
    begin
      mem_nxt = {mem_r[7:0], stored_byte};
      fill_nxt = fill_r + FILL_HALF;
    end
    else if (in_shift_go)
    begin
      mem_nxt = {mem_r[14:0], in_r[5]};
      fill_nxt = fill_r + 5'h01;
    end
    else if (to_out_go)
    begin
      mem_nxt = rev_sel ? 16'h0000 : {mem_r[7:0], 8'h00};
      fill_nxt = rev_sel ? FILL_EMPTY : fill_r - FILL_HALF;
    end
    else if (out_shift_go)
    begin
      mem_nxt = {mem_r[14:0], 1'b0};
      fill_nxt = fill_r - 5'h01;
    end
  end

  // Run control
  always_comb
  begin
    running_nxt = running_r;
    if (cmd[CMD_START])
    begin
      running_nxt = 1'b1;
    end
    if (halt_now)
    begin
      running_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= access & ~ack_r;
      if (AVS_READ & ~ack_r)
      begin
        unique case (AVS_ADDRESS[4:2])
          OFS_MODE[4:2]: rdata_r <= {26'h0, mode_r};
          OFS_SWITCH[4:2]: rdata_r <= {9'h0, switch_r};
          OFS_STATUS[4:2]: rdata_r <= {8'h0, fill_r, out_start, out_end,
                                      mem_eob, in_flags, in_control,
                                      emerg_pend_r, halt_pend_r, par_err_r,
                                      out_err_r, in_err_r, running_r};
          OFS_DATA[4:2]: rdata_r <= {7'h0, 9'(addr_r), out_r, in_r};
          OFS_MEMBUF[4:2]: rdata_r <= {16'h0, mem_r};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Panel switch settings, kept across clear
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      mode_r <= MODE_RESET;
      switch_r <= 23'h000000;
    end
    else if (wr_take & sel_mode)
    begin
      mode_r <= (mode_r & ~be_mask[5:0]) | wdata[5:0];
    end
    else if (wr_take & sel_switch)
    begin
      switch_r <= (switch_r & ~be_mask[22:0]) | wdata[22:0];
    end
  end

  // ----------------------------------------------------------------
  // Datapath registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (clr)
    begin
      in_r <= 8'h00;
      mem_r <= 16'h0000;
      fill_r <= FILL_EMPTY;
      addr_r <= '0;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
    end
    else
    begin
      mem_r <= mem_nxt;
      fill_r <= fill_nxt;
      wr_pend_r <= (fwd_take | dir_take | in_shift_go) &
                   (fill_nxt == FILL_FULL);
      rd_pend_r <= fetch_go;
      if (busy)
      begin
        addr_r <= addr_inc;
      end
      if (cmd[CMD_READ_IN])
      begin
        in_r <= input_switch_reg;
      end
      else if (run & IN_STROBE)
      begin
        in_r <= IN_DATA;
      end
      else if (in_shift_go)
      begin
        in_r <= {in_r[7:6], in_r[4:0], 1'b0};
      end
    end
  end

  // Output holding register and its strobe
  always_ff @(posedge REF_CLK)
  begin
    if (clr)
    begin
      out_r <= 8'h00;
      out_stb_r <= 1'b0;
    end
    else
    begin
      out_stb_r <= to_out_go;
      if (to_out_go)
      begin
        out_r <= rev_sel ? REV_CONV_DATA : direct_out;
      end
      else if (out_shift_go)
      begin
        out_r <= {out_r[7:6], out_r[4:0], mem_r[15]};
      end
    end
  end

  // Run, halt requests and latched errors; a new error beats clear
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      running_r <= 1'b0;
      halt_pend_r <= 1'b0;
      emerg_pend_r <= 1'b0;
      in_err_r <= 1'b0;
      out_err_r <= 1'b0;
      par_err_r <= 1'b0;
    end
    else
    begin
      running_r <= cmd_clear ? 1'b0 : running_nxt;
      halt_pend_r <= ~cmd_clear & ~halt_now &
                     (halt_pend_r | (run & cmd[CMD_HALT]));
      emerg_pend_r <= ~cmd_clear & ~(emerg_pend_r & op_cycle) &
                      (emerg_pend_r | (run & cmd[CMD_EMERG]));
      in_err_r <= (in_err_r & ~cmd_clear) | in_err_ev;
      out_err_r <= (out_err_r & ~cmd_clear) | out_err_ev;
      par_err_r <= (par_err_r & ~cmd_clear) |
                   (rd_pend_r & rd_par_bad);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign AVS_WAITREQUEST = access & ~ack_r;
  assign AVS_READDATA = rdata_r;
  assign FWD_CONV_IN = in_r;
  assign REV_CONV_IN = mem_r;
  assign MEM_ADDR = addr_r;
  assign MEM_WDATA = mem_r;
  assign MEM_WE = wr_pend_r;
  assign MEM_RD = fetch_go;
  assign OUT_DATA = out_r;
  assign OUT_STROBE = out_stb_r;
  assign RUNNING = running_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);

  property p_direct_fill;
    dir_take && fill_r == FILL_HALF && !cmd_clear |=> MEM_WE
      ##1 fill_r == FILL_EMPTY;
  endproperty
  a_direct_fill: assert property (p_direct_fill)
    else $error("full register not written to memory");

  property p_fetch_load;
    fetch_go && !cmd_clear |=> ##1 mem_r == $past(MEM_RDATA)
      && fill_r == FILL_FULL;
  endproperty
  a_fetch_load: assert property (p_fetch_load)
    else $error("memory word not loaded after fetch");

  property p_par_flag;
    rd_pend_r && rd_par_bad |=> par_err_r;
  endproperty
  a_par_flag: assert property (p_par_flag)
    else $error("memory parity error not flagged");

  property p_direct_out;
    to_out_go && !rev_sel && !cmd_clear |=> OUT_STROBE
      && OUT_DATA == $past(direct_out) && mem_r[15:8] == $past(mem_r[7:0]);
  endproperty
  a_direct_out: assert property (p_direct_out)
    else $error("direct output move wrong");

  property p_conv_load;
    fwd_take && !cmd_clear |=> mem_r == $past(FWD_CONV_DATA)
      && fill_r == FILL_FULL;
  endproperty
  a_conv_load: assert property (p_conv_load)
    else $error("converter word not loaded in parallel");

  property p_clear;
    cmd_clear |=> !running_r && fill_r == FILL_EMPTY && in_r == 8'h00
      && out_r == 8'h00 && !MEM_WE;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear left state behind");

  property p_emerg;
    emerg_pend_r && op_cycle && !cmd[CMD_START] |=> !running_r;
  endproperty
  a_emerg: assert property (p_emerg)
    else $error("emergency halt did not stop");

  property p_paper_ctrl;
    paper_in && (in_r[5] == in_r[6]) |-> in_control;
  endproperty
  a_paper_ctrl: assert property (p_paper_ctrl)
    else $error("paper tape control decode wrong");

  property p_err_halt;
    in_err_ev && !ignore_err && !cmd[CMD_START] |=> !running_r && in_err_r;
  endproperty
  a_err_halt: assert property (p_err_halt)
    else $error("data error did not halt");

  property p_latched;
    par_err_r && !cmd_clear |=> par_err_r;
  endproperty
  a_latched: assert property (p_latched)
    else $error("error flag dropped without clear");

endmodule

// [dv/mbd_far_model.sv]
// Far-side model: core memory and both code converters
`timescale 1ns/1ps
module mbd_far_model
#(
  parameter int ADDR_W = 9,
  parameter int MEM_WORDS = 336
)
(
  input wire logic clk,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_rd,
  output logic [15:0] mem_rdata,
  input wire logic [7:0] fwd_in,
  output logic [15:0] fwd_data,
  output logic fwd_err,
  input wire logic [15:0] rev_in,
  output logic [7:0] rev_data
);
  logic [15:0] ram [MEM_WORDS];

  // ----------------------------------------------------------------
  // Core memory
  // ----------------------------------------------------------------
  // Data only in the cycle after a read; scrambled otherwise
  initial mem_rdata = 16'h0000;
  always @(posedge clk)
  begin
    if (mem_rd)
      mem_rdata <= ram[mem_addr];
    else
      mem_rdata <= ~mem_rdata;
    if (mem_we)
      ram[mem_addr] <= mem_wdata;
  end

  // ----------------------------------------------------------------
  // Code converters
  // ----------------------------------------------------------------
  // Simple maps, only the forward one invertible; all ones has no equivalent
  assign fwd_data = {~fwd_in, fwd_in};
  assign fwd_err = (fwd_in == 8'hff);
  assign rev_data = rev_in[15:8] ^ rev_in[7:0];
endmodule

// [dv/media_buffer_register_datapath_bench.sv]
// Self-checking bench of the media buffer register datapath
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin \
  n_mismatch++; $display("Error %s expected %h seen %h", nm, e, s); \
  end end
module media_buffer_register_datapath_bench
  import mbd_pkg::*;
;
  typedef struct packed {logic [5:0] m; logic [7:0] b; logic [7:0] e;}
    mbd_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] addr = 5'h00;
  logic rd_e = 1'b0;
  logic wr_e = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] r;
  logic [3:0] be = 4'hf;
  logic waitreq;
  logic in_stb = 1'b0;
  logic [7:0] in_data = 8'h00;
  logic [7:0] fwd_in, rev_data, out_data;
  logic [15:0] fwd_data, mem_wdata, mem_rdata, rev_in;
  logic fwd_err, mem_we, mem_rd, out_stb, running;
  logic out_err = 1'b0;
  logic [8:0] mem_addr;
  int n_mismatch = 0;
  int compares = 0;
  int strobes = 0;
  // Status decode rows: mode, character, expected bits 13..6
  mbd_row_t rows [8] = '{'{6'h1, 8'hff, 8'h83}, '{6'h1, 8'h00, 8'h85},
    '{6'h0, 8'h4f, 8'h08}, '{6'h0, 8'h4e, 8'h90}, '{6'h0, 8'h4d, 8'ha0},
    '{6'h2, 8'h4c, 8'h40}, '{6'h0, 8'h3f, 8'h81}, '{6'h1, 8'h40, 8'h00}};

  // ----------------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------------
  mbd_datapath DUT (.REF_CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(addr),
    .AVS_READ(rd_e), .AVS_WRITE(wr_e), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .IN_STROBE(in_stb), .IN_DATA(in_data), .FWD_CONV_IN(fwd_in),
    .FWD_CONV_DATA(fwd_data), .FWD_CONV_ERR(fwd_err), .MEM_ADDR(mem_addr),
    .MEM_WDATA(mem_wdata), .MEM_WE(mem_we), .MEM_RD(mem_rd),
    .MEM_RDATA(mem_rdata), .REV_CONV_IN(rev_in),
    .REV_CONV_DATA(rev_data), .OUT_DATA(out_data), .OUT_STROBE(out_stb),
    .OUT_DEV_ERR(out_err), .RUNNING(running));
  mbd_far_model far (.clk(clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .fwd_in(fwd_in), .fwd_data(fwd_data), .fwd_err(fwd_err),
    .rev_in(rev_in), .rev_data(rev_data));

  // Clock and output strobe counter
  always #25 clk = ~clk;
  always @(posedge clk)
    if (out_stb === 1'b1)
      strobes++;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d);
    begin
      @(posedge clk);
      wr_e <= w;
      rd_e <= ~w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      while (waitreq !== 1'b0)
      begin
        @(posedge clk);
      end
      r = rdata;
      wr_e <= 1'b0;
      rd_e <= 1'b0;
    end
  endtask
  task automatic cmd(input int n);
    bus(1'b1, OFS_CMD, 32'h1 << n);
    repeat (3) @(posedge clk);
  endtask
  task automatic put(input logic [7:0] b);
    @(posedge clk);
    in_stb <= 1'b1;
    in_data <= b;
    @(posedge clk);
    in_stb <= 1'b0;
  endtask
  task automatic restart(input logic [5:0] m);
    bus(1'b1, OFS_MODE, {26'h0, m});
    cmd(CMD_CLEAR);
    cmd(CMD_START);
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("status", 32'h0000e140, r);
    cmd(CMD_START);
    `CHK("running", 1'b1, running);
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, OFS_MODE, {26'h0, rows[i].m});
      put(rows[i].b);
      bus(1'b0, OFS_DATA, 32'h0);
      `CHK("in_reg", rows[i].b, r[7:0]);
      bus(1'b0, OFS_STATUS, 32'h0);
      `CHK("decode", rows[i].e, r[13:6]);
    end
    // Direct packing of two characters and the memory write
    restart(IN_MAG);
    put(8'h01);
    cmd(CMD_TO_MEM);
    bus(1'b0, OFS_MEMBUF, 32'h0);
    `CHK("membuf", 16'h0001, r[15:0]);
    put(8'h07);
    cmd(CMD_TO_MEM);
    `CHK("mem0", 16'h0107, far.ram[0]);
    bus(1'b0, OFS_DATA, 32'h0);
    `CHK("addr", 9'h001, r[24:16]);
    // Paper tape character gets odd parity and mag format
    restart(IN_PAPER);
    put(8'h03);
    cmd(CMD_TO_MEM);
    bus(1'b0, OFS_MEMBUF, 32'h0);
    `CHK("paper", 16'h0083, r[15:0]);
    // Bad parity halts, stays latched, ignore keeps running
    restart(IN_MAG);
    put(8'h03);
    cmd(CMD_TO_MEM);
    `CHK("halted", 1'b0, running);
    cmd(CMD_START);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("in_err", 1'b1, r[1]);
    restart(6'h20);
    put(8'h03);
    cmd(CMD_TO_MEM);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("in_err", 1'b1, r[1]);
    `CHK("running", 1'b1, running);
    cmd(CMD_CLEAR);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("cleared", 4'h0, r[3:0]);
    `CHK("mem_kept", 16'h0107, far.ram[0]);
    // Forward converter path and its error
    restart(6'h10);
    put(8'h05);
    cmd(CMD_TO_MEM);
    `CHK("conv", 16'hfa05, far.ram[0]);
    put(8'hff);
    cmd(CMD_TO_MEM);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("conv_err", 1'b1, r[1]);
    // Fetch, two output moves, marks and normal halt
    restart(IN_MAG);
    far.ram[0] = 16'h4a4c;
    cmd(CMD_FETCH);
    bus(1'b0, OFS_MEMBUF, 32'h0);
    `CHK("fetch", 16'h4a4c, r[15:0]);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("eob", 1'b1, r[16]);
    `CHK("fill", 5'h10, r[23:19]);
    `CHK("par_ok", 1'b0, r[3]);
    cmd(CMD_TO_OUT);
    `CHK("out1", 8'h4a, out_data);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("end_mark", 1'b1, r[17]);
    cmd(CMD_HALT);
    `CHK("running", 1'b1, running);
    cmd(CMD_TO_OUT);
    `CHK("out2", 8'h4c, out_data);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("start_mark", 1'b1, r[18]);
    `CHK("halted", 1'b0, running);
    `CHK("strobes", 2, strobes);
    // Memory parity error without halt
    restart(IN_MAG);
    far.ram[0] = 16'h0301;
    cmd(CMD_FETCH);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("par_err", 1'b1, r[3]);
    `CHK("running", 1'b1, running);
    cmd(CMD_EMERG);
    put(8'h01);
    @(posedge clk);
    `CHK("emerg", 1'b0, running);
    // Manual read-in and an unmapped offset
    bus(1'b1, OFS_SWITCH, 32'h0000005a);
    cmd(CMD_READ_IN);
    bus(1'b0, OFS_DATA, 32'h0);
    `CHK("read_in", 8'h5a, r[7:0]);
    bus(1'b0, 5'h1c, 32'h0);
    `CHK("unmapped", 32'h0, r);
    // Column shifts, reverse converter, paper output, output error
    restart(6'h12);
    put(8'hd5);
    cmd(CMD_IN_SHIFT);
    cmd(CMD_IN_SHIFT);
    bus(1'b0, OFS_DATA, 32'h0);
    `CHK("in_shift", 8'hd4, r[7:0]);
    bus(1'b0, OFS_MEMBUF, 32'h0);
    `CHK("col_bits", 16'h0001, r[15:0]);
    restart(6'h12);
    far.ram[0] = 16'h8301;
    far.ram[1] = 16'h8301;
    cmd(CMD_FETCH);
    cmd(CMD_TO_OUT);
    `CHK("rev_out", 8'h82, out_data);
    cmd(CMD_FETCH);
    cmd(CMD_OUT_SHIFT);
    bus(1'b0, OFS_DATA, 32'h0);
    `CHK("out_shift", 8'h85, r[15:8]);
    bus(1'b0, OFS_MEMBUF, 32'h0);
    `CHK("mem_shift", 16'h0602, r[15:0]);
    restart(6'h04);
    far.ram[0] = 16'h8301;
    cmd(CMD_FETCH);
    cmd(CMD_TO_OUT);
    `CHK("paper_out", 8'h03, out_data);
    @(posedge clk);
    out_err <= 1'b1;
    @(posedge clk);
    out_err <= 1'b0;
    @(posedge clk);
    `CHK("out_halt", 1'b0, running);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("out_err", 1'b1, r[2]);
    stop_test();
  end

  // Watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
endmodule
